//--- rtl/crm_pfc_cycle_control.sv
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/100ps
// cycle logic of a boundary conduction mode boost stage
module crm_pfc_cycle_control #(
    parameter int WDOG_CYCLES = crm_pkg::WDOG_CYC
) (
    input wire logic ref_clk,
    input wire logic rst,
    input crm_pkg::crm_cmp_t cmpIn,
    input wire logic [1:0] regAddr,
    input wire logic [crm_pkg::IRQ_W-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [crm_pkg::IRQ_W-1:0] regRdata,
    output logic irq,
    output logic boost_gate_drive,
    output logic rampDischarge,
    output logic enabled
);
    crm_pkg::crm_cmp_t cmp;
    crm_pkg::crm_state_t state_ff;
    crm_pkg::crm_state_t nxt_state;
    logic enable_ff;
    logic zcdArmed_ff;
    logic rampHold_ff;
    logic blankDone;
    logic wdogDone;
    logic wdogClr;
    logic pulseStart;
    logic pulseEnd;
    logic ocpEnd;
    logic zcdFire;
    logic faultBlock;
    logic [crm_pkg::IRQ_W-1:0] stat_ff;
    logic [crm_pkg::IRQ_W-1:0] mask_ff;
    logic [crm_pkg::IRQ_W-1:0] events;
    logic [crm_pkg::IRQ_W-1:0] rdata_ff;

    // register decode shared by the write and read paths
    function automatic logic addr_is(input logic [1:0] addr, input logic [1:0] sel);
        return addr == sel;
    endfunction

    // every comparator comes from the analog domain
    crm_sync #(
        .W($bits(crm_pkg::crm_cmp_t))
    ) u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .din(cmpIn),
        .dout(cmp)
    );

    // enable latches on supply ready plus feedback above the high level
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            enable_ff <= 1'b0;
        end else if (!cmp.supplyReady || cmp.fbBelowLow) begin
            enable_ff <= 1'b0;
        end else if (cmp.fbAboveHigh) begin
            enable_ff <= 1'b1;
        end
    end

    assign faultBlock = !enable_ff || cmp.fbBelowLow || cmp.overVoltage || cmp.controlBelowMin;

    // zero-crossing arm/fire; pulse start disarms so each cycle needs a fresh arm
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            zcdArmed_ff <= 1'b0;
        end else if (pulseStart) begin
            zcdArmed_ff <= 1'b0;
        end else if (state_ff != crm_pkg::ST_ON && cmp.demagArm) begin
            zcdArmed_ff <= 1'b1;
        end
    end

    assign zcdFire = zcdArmed_ff && !cmp.demagArm && cmp.demagTrig;

    // watchdog cleared on pulse start and under feedback undervoltage
    assign wdogClr = pulseStart || cmp.fbBelowLow;
    crm_timer #(
        .W(crm_pkg::CNT_W),
        .LIMIT(WDOG_CYCLES)
    ) u_wdog (
        .ref_clk(ref_clk),
        .rst(rst),
        .clr(wdogClr),
        .done(wdogDone)
    );

    // leading-edge blanking restarts with each pulse
    crm_timer #(
        .W(crm_pkg::CNT_W),
        .LIMIT(crm_pkg::BLANK_CYC)
    ) u_blank (
        .ref_clk(ref_clk),
        .rst(rst),
        .clr(pulseStart),
        .done(blankDone)
    );

    assign pulseStart = (state_ff == crm_pkg::ST_WAIT) && !faultBlock && (zcdFire || wdogDone);
    assign ocpEnd = cmp.overCurrent && blankDone;
    // control match ends the on-time; peak ramp is the hard cap if control sits above it
    assign pulseEnd = cmp.rampPeak || cmp.rampAtControl || ocpEnd || faultBlock;

    // pulse state machine
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            crm_pkg::ST_OFF: begin
                if (enable_ff) begin
                    nxt_state = crm_pkg::ST_WAIT;
                end
            end
            crm_pkg::ST_WAIT: begin
                if (!enable_ff) begin
                    nxt_state = crm_pkg::ST_OFF;
                end else if (pulseStart) begin
                    nxt_state = crm_pkg::ST_ON;
                end
            end
            crm_pkg::ST_ON: begin
                if (!enable_ff) begin
                    nxt_state = crm_pkg::ST_OFF;
                end else if (pulseEnd && blankDone) begin
                    nxt_state = crm_pkg::ST_WAIT;
                end else if (cmp.rampPeak || faultBlock) begin
                    nxt_state = crm_pkg::ST_WAIT;
                end
            end
            default: begin
                nxt_state = crm_pkg::ST_OFF;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_ff <= crm_pkg::ST_OFF;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // gate output from a flop to keep glitches off the driver
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            boost_gate_drive <= 1'b0;
        end else begin
            boost_gate_drive <= (nxt_state == crm_pkg::ST_ON);
        end
    end

    // ramp held low from control match until the next pulse begins
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rampHold_ff <= 1'b1;
        end else if (pulseStart) begin
            rampHold_ff <= 1'b0;
        end else if (cmp.rampAtControl || state_ff != crm_pkg::ST_ON) begin
            rampHold_ff <= 1'b1;
        end
    end

    assign rampDischarge = rampHold_ff;
    assign enabled = enable_ff;

    // sticky events; set wins over a write-one clear in the same cycle
    assign events = {pulseStart && !zcdFire, cmp.fbBelowLow && enable_ff,
                     cmp.overVoltage, ocpEnd && state_ff == crm_pkg::ST_ON};
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            stat_ff <= '0;
        end else begin
            stat_ff <= (stat_ff & ~((regWr && addr_is(regAddr, crm_pkg::ADDR_STAT)) ? regWdata : '0)) | events;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mask_ff <= '0;
        end else if (regWr && addr_is(regAddr, crm_pkg::ADDR_MASK)) begin
            mask_ff <= regWdata;
        end
    end

    // read data valid the cycle after the strobe only; unmapped reads zero
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata_ff <= '0;
        end else if (!regRd) begin
            rdata_ff <= '0;
        end else if (addr_is(regAddr, crm_pkg::ADDR_STAT)) begin
            rdata_ff <= stat_ff;
        end else if (addr_is(regAddr, crm_pkg::ADDR_MASK)) begin
            rdata_ff <= mask_ff;
        end else if (addr_is(regAddr, crm_pkg::ADDR_LIVE)) begin
            rdata_ff <= {boost_gate_drive, zcdArmed_ff, rampHold_ff, enable_ff};
        end else begin
            rdata_ff <= '0;
        end
    end

    assign regRdata = rdata_ff;
    assign irq = |(stat_ff & mask_ff);
endmodule

//--- rtl/crm_pkg.sv
// Contract
// - end the gate pulse when the ramp reaches its peak level
// - discharge the ramp and hold it low once ramp plus offset hits control
// - start a cycle on zero crossing or watchdog expiry, whichever first
// - zero-crossing arms on a rising crossing, fires on a falling one
// - watchdog launches a pulse after 180 us without any pulse
// - clear the watchdog at every pulse start and during feedback undervoltage
// - control below clamp plus offset gives no pulses at all
// - disable the controller while feedback is below the low undervoltage level
// - suppress pulses while overvoltage is flagged; resume when it clears
// - overcurrent ends the current pulse at once, every cycle
// - ignore overcurrent during the blanking window at pulse start
// - enable only after supply ready and feedback above the high level
package crm_pkg;
    localparam int CLK_HZ = 10000000;
    localparam int WDOG_NS = 180000;
    localparam int BLANK_NS = 110;
    localparam int WDOG_CYC = (WDOG_NS / 1000) * (CLK_HZ / 1000000);
    localparam int BLANK_CYC_RAW = (BLANK_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int BLANK_CYC = (BLANK_CYC_RAW < 1) ? 1 : BLANK_CYC_RAW;
    localparam int CNT_W = 16;

    // comparator outputs as they arrive from the analog side
    typedef struct packed {
        logic supplyReady;
        logic fbAboveHigh;
        logic fbBelowLow;
        logic overVoltage;
        logic overCurrent;
        logic demagArm;
        logic demagTrig;
        logic rampPeak;
        logic rampAtControl;
        logic controlBelowMin;
    } crm_cmp_t;

    typedef enum logic [1:0] {
        ST_OFF = 2'b00,
        ST_WAIT = 2'b01,
        ST_ON = 2'b11
    } crm_state_t;

    localparam int IRQ_W = 4;
    localparam logic [1:0] ADDR_STAT = 2'h0;
    localparam logic [1:0] ADDR_MASK = 2'h1;
    localparam logic [1:0] ADDR_LIVE = 2'h2;
    localparam int EV_OCP = 0;
    localparam int EV_OVP = 1;
    localparam int EV_UVP = 2;
    localparam int EV_WDOG = 3;
endpackage

//--- rtl/crm_sync.sv
`timescale 1ns/100ps
// two-flop synchroniser for a bundle of level inputs
module crm_sync #(
    parameter int W = 1
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_ff;

    // first stage feeds only the second stage
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            meta_ff <= '0;
            dout <= '0;
        end else begin
            meta_ff <= din;
            dout <= meta_ff;
        end
    end
endmodule

//--- rtl/crm_timer.sv
`timescale 1ns/100ps
// saturating up counter with clear; done is high once the limit is reached
module crm_timer #(
    parameter int W = 16,
    parameter int LIMIT = 1
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clr,
    output logic done
);
    logic [W-1:0] count_ff;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            count_ff <= '0;
        end else if (clr) begin
            count_ff <= '0;
        end else if (!done) begin
            count_ff <= count_ff + 1'b1;
        end
    end

    assign done = (count_ff >= W'(LIMIT));
endmodule

//--- tb/crm_cycle_props.sv
`timescale 1ns/100ps
// port watcher; input windows allow for the two-flop synchroniser
module crm_cycle_props #(
    parameter int WDOG_CYCLES = 20
) (
    input wire logic ref_clk,
    input wire logic rst,
    input crm_pkg::crm_cmp_t cmpIn,
    input wire logic boost_gate_drive,
    input wire logic rampDischarge,
    input wire logic enabled
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    logic quiet;
    logic [15:0] idle_ff;
    // nothing on the analog side blocks a pulse
    assign quiet = cmpIn.supplyReady && !cmpIn.fbBelowLow && !cmpIn.overVoltage && !cmpIn.controlBelowMin;
    // gate-low time, kept loose: any blocking condition restarts it
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            idle_ff <= 16'h0000;
        end else if (boost_gate_drive || !enabled || !quiet || cmpIn.overCurrent) begin
            idle_ff <= 16'h0000;
        end else begin
            idle_ff <= idle_ff + 16'h0001;
        end
    end
    peak_end_a: assert property (cmpIn.rampPeak [*4] |-> !boost_gate_drive) else $error("gate past peak");
    ramp_hold_a: assert property ($rose(cmpIn.rampAtControl) |-> ##[1:4] rampDischarge) else $error("no discharge");
    uv_off_a: assert property (cmpIn.fbBelowLow [*4] |-> !enabled && !boost_gate_drive) else $error("uv run");
    ov_off_a: assert property (cmpIn.overVoltage [*4] |-> !boost_gate_drive) else $error("ov pulse");
    zero_duty_a: assert property (cmpIn.controlBelowMin [*4] |-> !boost_gate_drive) else $error("min pulse");
    ocp_end_a: assert property ((boost_gate_drive && cmpIn.overCurrent) [*3] |=> !boost_gate_drive) else $error("oc");
    blank_hold_a: assert property ((quiet && !cmpIn.rampPeak) [*4] ##0 $rose(boost_gate_drive) |=> boost_gate_drive)
        else $error("short pulse");
    wdog_max_a: assert property (idle_ff <= 16'(WDOG_CYCLES + 8)) else $error("no restart");
endmodule

bind crm_pfc_cycle_control crm_cycle_props #(.WDOG_CYCLES(WDOG_CYCLES)) u_props (.ref_clk(ref_clk), .rst(rst),
    .cmpIn(cmpIn), .boost_gate_drive(boost_gate_drive), .rampDischarge(rampDischarge), .enabled(enabled));

//--- tb/crm_switch_model.sv
`timescale 1ns/100ps
// switch, ramp capacitor and demag winding seen as comparator levels
module crm_switch_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic boost_gate_drive,
    input wire logic rampDischarge,
    input crm_pkg::crm_cmp_t ovr,
    input wire logic zcdOn,
    input wire logic [3:0] onLen,
    output crm_pkg::crm_cmp_t cmp
);
    logic [3:0] ramp_ff;
    logic [3:0] off_ff;
    // ramp climbs until the device discharges it; saturates instead of wrapping
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ramp_ff <= 4'h0;
        end else if (rampDischarge) begin
            ramp_ff <= 4'h0;
        end else if (ramp_ff != 4'hF) begin
            ramp_ff <= ramp_ff + 4'h1;
        end
    end
    // time since switch turn-off, for the winding ring
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            off_ff <= 4'h0;
        end else if (boost_gate_drive) begin
            off_ff <= 4'h0;
        end else if (off_ff != 4'hF) begin
            off_ff <= off_ff + 4'h1;
        end
    end
    // demagTrig stays high at rest once off_ff reaches 4, so without arming only the watchdog may start
    always_comb begin
        cmp = ovr;
        cmp.rampPeak = ramp_ff >= 4'hC;
        cmp.rampAtControl = ramp_ff >= onLen;
        cmp.demagArm = zcdOn && off_ff >= 4'h1 && off_ff <= 4'h3;
        cmp.demagTrig = off_ff >= 4'h4;
    end
endmodule

//--- tb/crm_pfc_cycle_control_tb_top.sv
`timescale 1ns/100ps
// register reads scored through a queue; gate pulses counted on the falling clock
module crm_pfc_cycle_control_tb_top;
    localparam int WD = 40;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] regAddr = 2'h0;
    logic [3:0] regWdata = 4'h0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic rdPend = 1'b0;
    logic gPrev = 1'b0;
    logic [3:0] regRdata;
    logic irq, gate, rampDis, enabled;
    logic zcdOn = 1'b1;
    logic [3:0] onLen = 4'hF;
    logic [7:0] lfsr_ff = 8'h20;
    crm_pkg::crm_cmp_t cmpIn;
    crm_pkg::crm_cmp_t ovr = '0;
    logic [7:0] expQ[$];
    int n_errors = 0;
    int tests_run = 0;
    int pulses = 0;
    int g;
    always #50 ref_clk = ~ref_clk;
    crm_pfc_cycle_control #(.WDOG_CYCLES(WD)) i_dut (.ref_clk(ref_clk), .rst(rst), .cmpIn(cmpIn), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irq(irq), .boost_gate_drive(gate),
        .rampDischarge(rampDis), .enabled(enabled));
    crm_switch_model i_sw (.ref_clk(ref_clk), .rst(rst), .boost_gate_drive(gate), .rampDischarge(rampDis),
        .ovr(ovr), .zcdOn(zcdOn), .onLen(onLen), .cmp(cmpIn));
    task automatic report_and_stop();
        $display("errors %0d of %0d checks", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic chk(input logic ok, input string what);
        tests_run++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask
    // queue entry is {care mask, expected word}
    task automatic cmp_rd();
        logic [7:0] e;
        e = expQ.pop_front();
        chk((regRdata & e[7:4]) === (e[3:0] & e[7:4]), "read data");
    endtask
    // strobe is dropped and an edge passes, so no signal is set twice in one step
    task automatic wr(input logic [1:0] a, input logic [3:0] d);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge ref_clk);
        regWr <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [1:0] a, input logic [3:0] e, input logic [3:0] care);
        regAddr <= a;
        regRd <= 1'b1;
        expQ.push_back({care, e});
        @(posedge ref_clk);
        regRd <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic run(input int n, output int got);
        int p;
        p = pulses;
        repeat (n) @(posedge ref_clk);
        got = pulses - p;
    endtask
    // hold one comparator fault: pulses stop, its status flag (none for controlBelowMin) is read while held, pulses come back
    task automatic fault(input int b, input logic [3:0] ev);
        ovr[b] <= 1'b1;
        repeat (8) @(posedge ref_clk);
        run(200, g);
        chk(g == 0 && enabled === 1'(b != 7), "pulse under fault");
        rd(crm_pkg::ADDR_STAT, ev, 4'h7);
        rd(crm_pkg::ADDR_LIVE, {3'b001, 1'(b != 7)}, 4'hB);
        ovr[b] <= 1'b0;
        run(100, g);
        chk(g > 0, "no resume");
        wr(crm_pkg::ADDR_STAT, 4'h7);
    endtask
    always @(posedge ref_clk) begin
        if (rdPend) cmp_rd();
        rdPend <= regRd;
    end
    always @(negedge ref_clk) begin
        gPrev <= gate;
        if (gate && !gPrev) pulses++;
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        $display("mismatch at %0t: run hung", $time);
        report_and_stop();
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        chk(enabled === 1'b0, "enabled early");
        ovr.supplyReady <= 1'b1;
        ovr.fbAboveHigh <= 1'b1;
        run(8, g);
        chk(enabled === 1'b1, "not enabled");
        run(400, g);
        chk(g >= 12, "zero-crossing starts");
        zcdOn <= 1'b0;
        run(400, g);
        chk(g >= 7 && g <= 11, "watchdog rate");
        rd(crm_pkg::ADDR_STAT, 4'h8, 4'hF);
        for (int i = 0; i < 4; i++) begin
            lfsr_ff = lfsr_next(lfsr_ff);
            wr(crm_pkg::ADDR_MASK, lfsr_ff[3:0]);
            rd(crm_pkg::ADDR_MASK, lfsr_ff[3:0], 4'hF);
            chk(irq === lfsr_ff[3], "irq level");
        end
        wr(crm_pkg::ADDR_MASK, 4'h1);
        zcdOn <= 1'b1;
        ovr.overCurrent <= 1'b1;
        run(100, g);
        ovr.overCurrent <= 1'b0;
        rd(crm_pkg::ADDR_STAT, 4'h1, 4'h1);
        chk(irq === 1'b1, "ocp irq");
        wr(crm_pkg::ADDR_STAT, 4'h1);
        rd(crm_pkg::ADDR_STAT, 4'h0, 4'h1);
        chk(irq === 1'b0, "irq stuck");
        // a low control level must shorten the on-time and so raise the pulse rate
        onLen <= 4'h6;
        run(200, g);
        chk(g >= 11, "on-time end");
        onLen <= 4'hF;
        fault(6, 4'h2);
        fault(0, 4'h0);
        fault(7, 4'h4);
        wr(2'h3, 4'hF);
        rd(2'h3, 4'h0, 4'hF);
        @(posedge ref_clk);
        report_and_stop();
    end
endmodule
